/* src/ltgc_len_mem.sv */
`timescale 1ns/1ns
module ltgc_len_mem (
	// Clock and reset
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst,
	// Write port
	input  wire logic                                   wr_en,
	input  wire logic [ltgc_pkg::CH_W-1:0]              wr_sel,
	input  wire logic [ltgc_pkg::LEN_W-1:0]             wr_code,
	// All stored codes, straight from the storage flops
	output logic [ltgc_pkg::NUM_CH*ltgc_pkg::LEN_W-1:0] codes
);
	import ltgc_pkg::*;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_entry
			wire logic hit;
			assign hit = wr_en && (wr_sel == CH_W'(g));
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst)
					codes[g*LEN_W +: LEN_W] <= LEN_RESET;
				else if (hit)
					codes[g*LEN_W +: LEN_W] <= wr_code;
			end
		end
	endgenerate

endmodule // ltgc_len_mem

/* src/ltgc_pkg.sv */
// Function
// - Bit 6 set: receive outputs carry all-ones alarm while signal is lost.
// - No receive alarm insertion while master clock is held high.
// - Bit 5 zero keeps transmitter short protection on; one turns it off.
// - Global bit 4 zero selects HDB3/B8ZS; one selects plain AMI.
// - Zero substitution coding acts only with a unipolar system interface.
// - Global bit 3 picks a 32-bit or 64-bit deep attenuator store.
// - Global bit 2 picks one of two attenuator corner frequencies.
// - Position bits 1:0: bit 0 clear off, 01 transmit path, 11 receive path.
// - Index register low three bits select channel 0 to 7 directly.
// - Shaping data register reaches the indexed channel's line-length code.
// - Line-length code 000 means E1; codes 001 to 111 mean T1.
// - Line-length code reads back with every bit inverted.
package ltgc_pkg;

	// Geometry
	localparam int unsigned NUM_CH = 8;
	localparam int unsigned CH_W   = 3;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned LEN_W  = 3;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CONTROL = 8'h0F;
	localparam logic [ADDR_W-1:0] ADDR_SHAPING_INDEX  = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_SHAPING_DATA   = 8'h11;

	// Global control field positions
	localparam int unsigned GC_ALARM_BIT  = 6;
	localparam int unsigned GC_SHORT_BIT  = 5;
	localparam int unsigned GC_CODE_BIT   = 4;
	localparam int unsigned GC_DEPTH_BIT  = 3;
	localparam int unsigned GC_CORNER_BIT = 2;
	localparam int unsigned GC_POS_HI     = 1;
	localparam int unsigned GC_POS_LO     = 0;

	// Writable masks and reset values
	localparam logic [DATA_W-1:0] GC_WR_MASK  = 8'h7F;
	localparam logic [DATA_W-1:0] IDX_WR_MASK = 8'h07;
	localparam logic [DATA_W-1:0] GC_RESET    = 8'h00;
	localparam logic [CH_W-1:0]   IDX_RESET   = 3'h0;
	localparam logic [LEN_W-1:0]  LEN_RESET   = 3'h0;
	localparam logic [LEN_W-1:0]  LEN_E1      = 3'h0;

	// Attenuator position codes and store depths
	localparam logic [1:0] JA_POS_TX = 2'h1;
	localparam logic [1:0] JA_POS_RX = 2'h3;
	localparam logic [6:0] JA_DEPTH_SHALLOW = 7'h20;
	localparam logic [6:0] JA_DEPTH_DEEP    = 7'h40;

endpackage

/* src/ltgc_top.sv */
`timescale 1ns/1ns
module ltgc_top (
	// Clock and reset
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst,
	// Register port
	input  wire logic [ltgc_pkg::ADDR_W-1:0]            addr,
	input  wire logic [ltgc_pkg::DATA_W-1:0]            wr_data,
	input  wire logic                                   wr_en,
	input  wire logic                                   rd_en,
	output logic [ltgc_pkg::DATA_W-1:0]                 rd_data,
	// Line status and mode
	input  wire logic [ltgc_pkg::NUM_CH-1:0]            los,
	input  wire logic                                   mclk_high,
	input  wire logic                                   system_bipolar,
	// Receive data path
	input  wire logic [ltgc_pkg::NUM_CH-1:0]            rx_pos_in,
	input  wire logic [ltgc_pkg::NUM_CH-1:0]            rx_neg_in,
	output logic [ltgc_pkg::NUM_CH-1:0]                 rx_positive_data,
	output logic [ltgc_pkg::NUM_CH-1:0]                 rx_negative_data,
	// Transmit and coder controls
	output logic                                        short_protect_en,
	output logic                                        zero_sub_en,
	output logic [ltgc_pkg::NUM_CH-1:0]                 t1_mode,
	// Jitter attenuator controls
	output logic [6:0]                                  ja_depth,
	output logic                                        attenuator_corner_sel,
	output logic                                        ja_tx_en,
	output logic                                        ja_rx_en,
	// Per-channel line-length codes
	output logic [ltgc_pkg::NUM_CH*ltgc_pkg::LEN_W-1:0] line_length_code
);
	import ltgc_pkg::*;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction

	function automatic logic ais_on(input logic en, input logic lost,
		input logic recov);
		ais_on = en && lost && !recov;
	endfunction

	logic [DATA_W-1:0]      global_control;
	logic [CH_W-1:0]        shaping_channel_sel;
	logic [NUM_CH-1:0]      ais_phase;
	logic [DATA_W-1:0]      next_rd_data;

	wire logic              wr_gc;
	wire logic              wr_idx;
	wire logic              wr_len;
	wire logic              rd_gc;
	wire logic              rd_idx;
	wire logic              rd_len;
	wire logic [LEN_W-1:0]  cur_code;
	wire logic [NUM_CH-1:0] insert_vec;
	wire logic              rx_alarm_insert_en;
	wire logic              line_code_select;
	wire logic              deep_elastic_store;
	wire logic [1:0]        attenuator_position;
	wire logic [NUM_CH*LEN_W-1:0] sel_mask;

	// Address decode
	assign wr_gc  = wr_en && reg_hit(addr, ADDR_GLOBAL_CONTROL);
	assign wr_idx = wr_en && reg_hit(addr, ADDR_SHAPING_INDEX);
	assign wr_len = wr_en && reg_hit(addr, ADDR_SHAPING_DATA);
	assign rd_gc  = rd_en && reg_hit(addr, ADDR_GLOBAL_CONTROL);
	assign rd_idx = rd_en && reg_hit(addr, ADDR_SHAPING_INDEX);
	assign rd_len = rd_en && reg_hit(addr, ADDR_SHAPING_DATA);

	// Field views
	assign rx_alarm_insert_en  = global_control[GC_ALARM_BIT];
	assign line_code_select    = global_control[GC_CODE_BIT];
	assign deep_elastic_store  = global_control[GC_DEPTH_BIT];
	assign attenuator_position = global_control[GC_POS_HI:GC_POS_LO];

	// Selected channel's code
	assign cur_code = line_length_code[shaping_channel_sel*LEN_W +: LEN_W];

	// Bits of the selected channel within the code vector
	assign sel_mask = (NUM_CH*LEN_W)'({LEN_W{1'b1}}) <<
		(shaping_channel_sel * LEN_W);

	// Read mux, unmapped and idle cycles give zero
	always_comb begin
		next_rd_data = '0;
		if (rd_gc)
			next_rd_data = global_control & GC_WR_MASK;
		else if (rd_idx)
			next_rd_data = {5'h00, shaping_channel_sel};
		else if (rd_len)
			next_rd_data = {5'h00, ~cur_code};
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rd_data <= '0;
		else
			rd_data <= next_rd_data;
	end

	// Registers; reserved bits are masked on write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			global_control <= GC_RESET;
		else if (wr_gc)
			global_control <= wr_data & GC_WR_MASK;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			shaping_channel_sel <= IDX_RESET;
		else if (wr_idx)
			shaping_channel_sel <= wr_data[CH_W-1:0];
	end

	ltgc_len_mem u_len_mem (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wr_en   (wr_len),
		.wr_sel  (shaping_channel_sel),
		.wr_code (wr_data[LEN_W-1:0]),
		.codes   (line_length_code)
	);

	// Receive alarm insertion, one stage per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_rx
			assign insert_vec[g] = ais_on(rx_alarm_insert_en, los[g],
				mclk_high);
			// Bipolar all-ones alternates marks between the rails
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					ais_phase[g]        <= 1'b0;
					rx_positive_data[g] <= 1'b0;
					rx_negative_data[g] <= 1'b0;
				end else if (insert_vec[g]) begin
					ais_phase[g]        <= ~ais_phase[g];
					rx_positive_data[g] <= !system_bipolar ||
						!ais_phase[g];
					rx_negative_data[g] <= system_bipolar &&
						ais_phase[g];
				end else begin
					ais_phase[g]        <= 1'b0;
					rx_positive_data[g] <= rx_pos_in[g];
					rx_negative_data[g] <= rx_neg_in[g];
				end
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst)
					t1_mode[g] <= 1'b0;
				else
					t1_mode[g] <= line_length_code[g*LEN_W +: LEN_W]
						!= LEN_E1;
			end
		end
	endgenerate

	// Coder, protection and attenuator controls
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			short_protect_en      <= 1'b1;
			zero_sub_en           <= 1'b0;
			ja_depth              <= JA_DEPTH_SHALLOW;
			attenuator_corner_sel <= 1'b0;
			ja_tx_en              <= 1'b0;
			ja_rx_en              <= 1'b0;
		end else begin
			short_protect_en <= !global_control[GC_SHORT_BIT];
			zero_sub_en <= !line_code_select &&
				!system_bipolar;
			ja_depth <= deep_elastic_store ? JA_DEPTH_DEEP
				: JA_DEPTH_SHALLOW;
			attenuator_corner_sel <= global_control[GC_CORNER_BIT];
			ja_tx_en <= attenuator_position == JA_POS_TX;
			ja_rx_en <= attenuator_position == JA_POS_RX;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_UNI_AIS: assert property (
		(!system_bipolar && insert_vec != '0) |=>
		((rx_positive_data & $past(insert_vec)) == $past(insert_vec)))
		else $error("alarm ones missing on unipolar output");

	AST_PASS_THROUGH: assert property (
		!rst |=> ((rx_positive_data & ~$past(insert_vec)) ==
		($past(rx_pos_in) & ~$past(insert_vec))))
		else $error("receive data not passed through");

	AST_RECOVERY_NO_AIS: assert property (
		(mclk_high && !rst) |=> (rx_positive_data == $past(rx_pos_in)) &&
		(rx_negative_data == $past(rx_neg_in)))
		else $error("alarm inserted in data-recovery mode");

	AST_SHORT_PROTECT: assert property (
		wr_gc |-> ##2 short_protect_en == !$past(wr_data[GC_SHORT_BIT], 2))
		else $error("short protection does not follow bit 5");

	AST_CODE_UNIPOLAR: assert property (
		(wr_gc ##1 !system_bipolar) |=>
		zero_sub_en == !$past(wr_data[GC_CODE_BIT], 2))
		else $error("code select not applied");

	AST_CODE_BIPOLAR: assert property (
		system_bipolar |=> !zero_sub_en)
		else $error("zero substitution active in bipolar mode");

	AST_DEPTH: assert property (
		wr_gc |-> ##2 ja_depth == ($past(wr_data[GC_DEPTH_BIT], 2)
		? JA_DEPTH_DEEP : JA_DEPTH_SHALLOW))
		else $error("attenuator depth wrong");

	AST_CORNER: assert property (
		wr_gc |-> ##2 attenuator_corner_sel ==
		$past(wr_data[GC_CORNER_BIT], 2))
		else $error("corner select wrong");

	AST_POSITION: assert property (
		wr_gc |-> ##2 (ja_tx_en == ($past(wr_data[1:0], 2) == JA_POS_TX))
		&& (ja_rx_en == ($past(wr_data[1:0], 2) == JA_POS_RX)))
		else $error("attenuator position wrong");

	AST_INDEX: assert property (
		wr_idx |=> shaping_channel_sel == $past(wr_data[CH_W-1:0]))
		else $error("channel index not stored");

	AST_DATA_WRITE: assert property (
		wr_len |=> line_length_code[$past(shaping_channel_sel)*LEN_W
		+: LEN_W] == $past(wr_data[LEN_W-1:0]))
		else $error("line length not written to selected channel");

	AST_T1_MODE: assert property (
		!rst |=> t1_mode[0] ==
		($past(line_length_code[LEN_W-1:0]) != LEN_E1))
		else $error("operating mode wrong");

	AST_READ_INVERT: assert property (
		rd_len |=> rd_data == {5'h00, ~$past(cur_code)})
		else $error("line length read not inverted");

	AST_RESERVED: assert property (
		(rd_gc || rd_idx) |=> !rd_data[7] &&
		(!$past(rd_idx) || rd_data[7:3] == 5'h00))
		else $error("reserved bits read nonzero");

	// Register port idle values and holds
	AST_IDLE_READ: assert property (
		(!rd_en && !rst) |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");

	AST_GC_WRITE: assert property (
		wr_gc |=> !global_control[DATA_W-1] &&
		(global_control[GC_ALARM_BIT:0] == $past(wr_data[GC_ALARM_BIT:0])))
		else $error("global control write wrong");

	AST_IDX_HOLD: assert property (
		(!wr_idx && !rst) |=> $stable(shaping_channel_sel))
		else $error("channel index changed without a write");

	AST_LEN_OTHERS: assert property (
		wr_len |=> (line_length_code & ~$past(sel_mask)) ==
		($past(line_length_code) & ~$past(sel_mask)))
		else $error("line length write reached another channel");

	AST_LEN_HOLD: assert property (
		(!wr_len && !rst) |=> $stable(line_length_code))
		else $error("line length changed without a write");

	// Receive alarm shape on both rails
	AST_UNI_AIS_NEG: assert property (
		(!system_bipolar && insert_vec != '0) |=>
		((rx_negative_data & $past(insert_vec)) == '0))
		else $error("negative rail not quiet during unipolar alarm");

	AST_BIP_AIS: assert property (
		(system_bipolar && insert_vec != '0) |=>
		(((rx_positive_data ^ rx_negative_data) & $past(insert_vec)) ==
		$past(insert_vec)))
		else $error("bipolar alarm mark missing");

	AST_AIS_ALT: assert property (
		(system_bipolar && insert_vec[0]) ##1
		(system_bipolar && insert_vec[0]) |=>
		rx_positive_data[0] != $past(rx_positive_data[0]))
		else $error("bipolar alarm marks do not alternate");

	// Control outputs except zero_sub_en and t1_mode hold while the global register is left alone
	AST_CTRL_HOLD: assert property (
		(!wr_gc && !rst) |-> ##2 $stable({short_protect_en, ja_depth,
		attenuator_corner_sel, ja_tx_en, ja_rx_en}))
		else $error("control outputs changed without a write");

	COV_AIS: cover property (insert_vec[0] ##1 insert_vec[0]);
	COV_LEN_RW: cover property (wr_len ##1 rd_len);
	COV_JA_RX: cover property (ja_rx_en);
	COV_IDX_7: cover property (wr_idx && wr_data[2:0] == 3'h7);
	COV_BIP_AIS: cover property (system_bipolar && insert_vec != '0);

endmodule // ltgc_top

/* test/ltgc_testbench.sv */
`timescale 1ns/1ns
module testbench;
	import ltgc_pkg::*;

	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr, wr_data, rd_data, los, rx_pos_in, rx_neg_in;
	logic        wr_en, rd_en, mclk_high, system_bipolar;
	logic [7:0]  rx_positive_data, rx_negative_data, t1_mode;
	logic        short_protect_en, zero_sub_en, attenuator_corner_sel;
	logic        ja_tx_en, ja_rx_en;
	logic [6:0]  ja_depth;
	logic [23:0] line_length_code;
	int          n_fail, comparisons, bip, code[8];
	logic [7:0]  gc, d, ins, pl, pp, pn;
	logic        pm, pb;
	logic [25:0] pend[$];

	ltgc_top ltgc_top_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.los(los), .mclk_high(mclk_high), .system_bipolar(system_bipolar),
		.rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in),
		.rx_positive_data(rx_positive_data),
		.rx_negative_data(rx_negative_data),
		.short_protect_en(short_protect_en), .zero_sub_en(zero_sub_en),
		.t1_mode(t1_mode), .ja_depth(ja_depth),
		.attenuator_corner_sel(attenuator_corner_sel), .ja_tx_en(ja_tx_en),
		.ja_rx_en(ja_rx_en), .line_length_code(line_length_code));

	always #5 ref_clk = ~ref_clk;

	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, exp);
	endtask

	// Derived controls against the model of both registers
	task automatic chk_ctl();
		logic [7:0]  t1;
		logic [23:0] lens;
		for (int n = 0; n < 8; n++) begin
			t1[n] = code[n] != 0;
			lens[3*n +: 3] = code[n][2:0];
		end
		chk(short_protect_en, !gc[5]);
		chk(zero_sub_en, !gc[4] && bip == 0);
		chk(ja_depth, gc[3] ? 32'h40 : 32'h20);
		chk(attenuator_corner_sel, gc[2]);
		chk(ja_tx_en, gc[1:0] == 2'h1);
		chk(ja_rx_en, gc[1:0] == 2'h3);
		chk(t1_mode, t1);
		chk(line_length_code, lens);
	endtask

	task automatic reset_checks();
		gc = 8'h00;
		foreach (code[n]) code[n] = 0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk_ctl();
		rd(8'h0F, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h11, 8'h07);
	endtask

	initial begin
		{addr, wr_data, wr_en, rd_en, los, mclk_high} = '0;
		{system_bipolar, rx_pos_in, rx_neg_in, n_fail, comparisons, bip} = '0;
		void'($urandom(66));
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		reset_checks();
		// Every position code, random other bits and supply form
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			bip = $urandom % 2;
			system_bipolar <= bip[0];
			d = ($urandom & 8'hFC) | i[1:0];
			wr(8'h0F, d);
			gc = d & 8'h7F;
			rd(8'h0F, gc);
			@(posedge ref_clk);
			#1;
			chk_ctl();
		end
		// Channel n gets line code n, index then data with one idle cycle between
		for (int ch = 0; ch < 8; ch++) begin
			wr(8'h10, ($urandom & 8'hF8) | ch[2:0]);
			d = ($urandom & 8'hF8) | ch[2:0];
			wr(8'h11, d);
			code[ch] = ch;
			rd(8'h11, ~d & 8'h07);
			rd(8'h10, ch[7:0]);
		end
		wr(8'h10, 8'h02);
		rd(8'h11, 8'h05);
		repeat (2) @(posedge ref_clk);
		#1;
		chk_ctl();
		// Unmapped places ignore writes and read zero
		wr(8'h12, 8'hFF);
		wr(8'h0E, 8'hFF);
		rd(8'h12, 8'h00);
		rd(8'h0E, 8'h00);
		rd(8'h0F, gc);
		// Receive path with the alarm enable off and on
		for (int e = 0; e < 2; e++) begin
			gc[6] = e[0];
			wr(8'h0F, gc);
			repeat (3) @(posedge ref_clk);
			pend.delete();
			pend.push_back({los, rx_pos_in, rx_neg_in, mclk_high,
				system_bipolar});
			repeat (150) begin
				@(posedge ref_clk);
				{pl, pp, pn, pm, pb} = pend.pop_front();
				ins = (gc[6] && !pm) ? pl : 8'h00;
				los <= $urandom;
				rx_pos_in <= $urandom;
				rx_neg_in <= $urandom;
				mclk_high <= ($urandom % 4) == 0;
				system_bipolar <= $urandom;
				#1;
				chk(rx_positive_data & ~ins, pp & ~ins);
				chk(rx_negative_data & ~ins, pn & ~ins);
				if (!pb) begin
					chk(rx_positive_data & ins, ins);
					chk(rx_negative_data & ins, 8'h00);
				end else begin
					chk((rx_positive_data ^ rx_negative_data) & ins, ins);
				end
				pend.push_back({los, rx_pos_in, rx_neg_in, mclk_high,
					system_bipolar});
			end
		end
		// Second reset in mid-run
		@(posedge ref_clk);
		system_bipolar <= 1'b1;
		bip = 1;
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		reset_checks();
		complete_run();
	end

	// Guard against a hung run
	initial begin
		#500000;
		n_fail++;
		complete_run();
	end
endmodule // testbench
